/* File: verilog/ueci_pkg.sv */
`default_nettype none
package ueci_pkg;
   localparam int ADDR_W = 8;
   localparam int IDX_W = 6;
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_POWER = 6'h01;
   localparam logic [IDX_W-1:0] IDX_IN_FLG = 6'h02;
   localparam logic [IDX_W-1:0] IDX_OUT_FLG = 6'h04;
   localparam logic [IDX_W-1:0] IDX_CM_FLG = 6'h06;
   localparam logic [IDX_W-1:0] IDX_IN_IE = 6'h07;
   localparam logic [IDX_W-1:0] IDX_OUT_IE = 6'h09;
   localparam logic [IDX_W-1:0] IDX_CM_IE = 6'h0B;
   localparam logic [IDX_W-1:0] IDX_EP_SEL = 6'h0E;
   localparam logic [IDX_W-1:0] IDX_E0_CSR = 6'h11;
   localparam logic [IDX_W-1:0] IDX_E0_CNT = 6'h16;
   localparam logic [IDX_W-1:0] IDX_E0_FIFO = 6'h20;
   localparam logic [3:0] EP0_SEL = 4'h0;
   localparam logic [3:0] IN_IE_RST = 4'hF;
   localparam logic [3:0] OUT_IE_RST = 4'hE;
   localparam logic [3:0] OUT_IE_MSK = 4'hE;
   localparam logic [3:0] CM_IE_RST = 4'h6;
   // common event bits
   localparam int CM_SUS = 0;
   localparam int CM_RSU = 1;
   localparam int CM_RST = 2;
   localparam int CM_SOF = 3;
   // control endpoint status bits
   localparam int CS_OUT_RDY = 0;
   localparam int CS_IN_RDY = 1;
   localparam int CS_SENT_STL = 2;
   localparam int CS_DEND = 3;
   localparam int CS_SETUP_END = 4;
   localparam int CS_SEND_STL = 5;
   localparam int CS_SRV_OUT = 6;
   localparam int CS_SRV_SU = 7;
   // power register bits
   localparam int PW_SUS_EN = 0;
   localparam int PW_SUS_MD = 1;
   // synchronised line conditions
   localparam int LN_SUS = 0;
   localparam int LN_RSU = 1;
   localparam int LN_RST = 2;
   localparam logic [1:0] PID_SETUP = 2'h0;
   localparam logic [1:0] PID_OUT = 2'h1;
   localparam logic [1:0] PID_IN = 2'h2;
   localparam logic [1:0] PID_SOF = 2'h3;
   localparam logic [1:0] HS_ACK = 2'h0;
   localparam logic [1:0] HS_NAK = 2'h1;
   localparam logic [1:0] HS_STALL = 2'h2;
   localparam logic [1:0] HS_DATA = 2'h3;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   localparam logic [6:0] SETUP_LEN = 7'h08;
   localparam int EP0_MAX_DEF = 64;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int FRAME_US = 1000;
   localparam int FRAME_CYC_DEF = FRAME_US * 1000 * 1000 / CLK_PERIOD_PS;
   typedef enum logic [2:0] {PH_IDLE, PH_TX_MODE, PH_TX_DONE, PH_RX_MODE, PH_RX_DONE} ueci_phase_e;
   typedef enum logic [1:0] {TR_NONE, TR_RX, TR_TX, TR_ACK} ueci_tr_e;
endpackage
`default_nettype wire

/* File: verilog/ueci_fifo_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module ueci_fifo_mem #(
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic aclk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data_r
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge aclk) begin
      rd_data_r <= mem[rd_addr];
   end
endmodule // ueci_fifo_mem
`default_nettype wire

/* File: verilog/ueci_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ueci_top
   import ueci_pkg::*;
#(
   parameter int FRAME_CYCLES = FRAME_CYC_DEF,
   parameter int EP0_MAX = EP0_MAX_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic line_reset,
   input wire logic line_resume,
   input wire logic line_suspend,
   input wire logic tok_valid,
   input wire logic [1:0] tok_pid,
   input wire logic [3:0] tok_ep,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_end,
   input wire logic rx_err,
   input wire logic rx_data1,
   input wire logic host_ack,
   output logic resp_valid,
   output logic [1:0] resp_kind,
   output logic [6:0] resp_len,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   input wire logic [2:0] in_ep_event,
   input wire logic [2:0] out_ep_event,
   output logic usb_irq
);
   localparam int AW = $clog2(EP0_MAX);
   localparam int FC_W = $clog2(FRAME_CYCLES + 1);
   localparam logic [6:0] MAX7 = 7'(EP0_MAX);
   localparam logic [FC_W-1:0] FC_LAST = FC_W'(FRAME_CYCLES - 1);

   function automatic logic f_ep0_hit(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] tgt,
                                      input logic [3:0] sel);
      return (idx == tgt) && (sel == EP0_SEL);
   endfunction

   function automatic logic f_mapped(input logic [IDX_W-1:0] idx);
      return idx == IDX_POWER || idx == IDX_IN_FLG || idx == IDX_OUT_FLG || idx == IDX_CM_FLG ||
             idx == IDX_IN_IE || idx == IDX_OUT_IE || idx == IDX_CM_IE || idx == IDX_EP_SEL ||
             idx == IDX_E0_CSR || idx == IDX_E0_CNT || idx == IDX_E0_FIFO;
   endfunction

   logic [2:0] ln_s1_r, ln_s2_r, ln_s3_r;
   logic [2:0] ln_rise;
   logic suspended_r, sus_en_r, sof_seen_r, sof_evt;
   logic [FC_W-1:0] frame_cnt_r;
   logic [3:0] cm_flg_r, in_flg_r, out_flg_r, cm_ie_r, in_ie_r, out_ie_r, ep_sel_r, cm_set;
   logic aw_held_r, w_held_r, rd_go_r, wr_do, wr_ok, rd_clr;
   logic [IDX_W-1:0] aw_idx_r, rd_idx_r;
   logic [7:0] w_dat_r, rd_byte, csr_val, mem_q;
   logic w_stb_r;
   ueci_phase_e phase_r;
   ueci_tr_e tr_r;
   logic out_rdy_r, in_rdy_r, sent_stl_r, dend_r, setup_end_r, send_stl_r, ep0_evt_r;
   logic rx_setup_r, rx_take_r, rx_ovf_r, status_r, fetch_r;
   logic [6:0] rx_len_r, cnt_r, tx_len_r, tx_ptr_r, sw_rd_ptr_r;
   logic sw_csr_wr, sw_fifo_wr, sw_fifo_rd, mem_we, ep0_tok;
   logic [AW-1:0] mem_wa, mem_ra;
   logic [7:0] mem_wd;

   // line conditions arrive asynchronously
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ln_s1_r <= 3'h0;
         ln_s2_r <= 3'h0;
         ln_s3_r <= 3'h0;
      end else begin
         ln_s1_r <= {line_reset, line_resume, line_suspend};
         ln_s2_r <= ln_s1_r;
         ln_s3_r <= ln_s2_r;
      end
   end
   assign ln_rise = ln_s2_r & ~ln_s3_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         suspended_r <= 1'b0;
      end else if (ln_rise[LN_RSU] || ln_rise[LN_RST]) begin
         suspended_r <= 1'b0;
      end else if (ln_rise[LN_SUS] && sus_en_r) begin
         suspended_r <= 1'b1;
      end
   end

   // frame timer keeps the frame event going when a token is lost
   assign sof_evt = (tok_valid && tok_pid == PID_SOF) || (sof_seen_r && frame_cnt_r == FC_LAST);
   always_ff @(posedge aclk) begin
      if (!aresetn || ln_rise[LN_RST] || suspended_r) begin
         sof_seen_r <= 1'b0;
         frame_cnt_r <= '0;
      end else if (sof_evt) begin
         sof_seen_r <= 1'b1;
         frame_cnt_r <= '0;
      end else if (sof_seen_r) begin
         frame_cnt_r <= frame_cnt_r + 1'b1;
      end
   end

   always_comb begin
      cm_set = 4'h0;
      cm_set[CM_SOF] = sof_evt;
      cm_set[CM_RST] = ln_rise[LN_RST];
      cm_set[CM_RSU] = ln_rise[LN_RSU] && suspended_r;
      cm_set[CM_SUS] = ln_rise[LN_SUS] && sus_en_r;
   end

   // flags: a set in the clearing cycle survives
   assign rd_clr = rd_go_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cm_flg_r <= 4'h0;
         in_flg_r <= 4'h0;
         out_flg_r <= 4'h0;
      end else begin
         cm_flg_r <= (rd_clr && rd_idx_r == IDX_CM_FLG ? 4'h0 : cm_flg_r) | cm_set;
         in_flg_r <= (rd_clr && rd_idx_r == IDX_IN_FLG ? 4'h0 : in_flg_r) | {in_ep_event, ep0_evt_r};
         out_flg_r <= (rd_clr && rd_idx_r == IDX_OUT_FLG ? 4'h0 : out_flg_r) | {out_ep_event, 1'b0};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         usb_irq <= 1'b0;
      end else begin
         usb_irq <= |(cm_flg_r & cm_ie_r) | |(in_flg_r & in_ie_r) | |(out_flg_r & out_ie_r);
      end
   end

   // axi write channel
   assign wr_do = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_ok = wr_do && w_stb_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_idx_r <= '0;
         w_dat_r <= 8'h00;
         w_stb_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[ADDR_W-1:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held_r <= 1'b1;
            w_dat_r <= s_axi_wdata[7:0];
            w_stb_r <= s_axi_wstrb[0];
         end
         if (wr_do) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= f_mapped(aw_idx_r) ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // software-owned settings
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sus_en_r <= 1'b0;
         in_ie_r <= IN_IE_RST;
         out_ie_r <= OUT_IE_RST;
         cm_ie_r <= CM_IE_RST;
         ep_sel_r <= EP0_SEL;
      end else if (wr_ok) begin
         if (aw_idx_r == IDX_POWER) begin
            sus_en_r <= w_dat_r[PW_SUS_EN];
         end else if (aw_idx_r == IDX_IN_IE) begin
            in_ie_r <= w_dat_r[3:0];
         end else if (aw_idx_r == IDX_OUT_IE) begin
            out_ie_r <= w_dat_r[3:0] & OUT_IE_MSK;
         end else if (aw_idx_r == IDX_CM_IE) begin
            cm_ie_r <= w_dat_r[3:0];
         end else if (aw_idx_r == IDX_EP_SEL) begin
            ep_sel_r <= w_dat_r[3:0];
         end
      end
   end

   // axi read channel: data two edges after the address
   always_comb begin
      csr_val = 8'h00;
      csr_val[CS_OUT_RDY] = out_rdy_r;
      csr_val[CS_IN_RDY] = in_rdy_r;
      csr_val[CS_SENT_STL] = sent_stl_r;
      csr_val[CS_DEND] = dend_r;
      csr_val[CS_SETUP_END] = setup_end_r;
      csr_val[CS_SEND_STL] = send_stl_r; // serviced bits read zero
      rd_byte = 8'h00;
      if (rd_idx_r == IDX_POWER) begin
         rd_byte[PW_SUS_EN] = sus_en_r;
         rd_byte[PW_SUS_MD] = suspended_r;
      end else if (rd_idx_r == IDX_IN_FLG) begin
         rd_byte[3:0] = in_flg_r;
      end else if (rd_idx_r == IDX_OUT_FLG) begin
         rd_byte[3:0] = out_flg_r;
      end else if (rd_idx_r == IDX_CM_FLG) begin
         rd_byte[3:0] = cm_flg_r;
      end else if (rd_idx_r == IDX_IN_IE) begin
         rd_byte[3:0] = in_ie_r;
      end else if (rd_idx_r == IDX_OUT_IE) begin
         rd_byte[3:0] = out_ie_r;
      end else if (rd_idx_r == IDX_CM_IE) begin
         rd_byte[3:0] = cm_ie_r;
      end else if (rd_idx_r == IDX_EP_SEL) begin
         rd_byte[3:0] = ep_sel_r;
      end else if (f_ep0_hit(rd_idx_r, IDX_E0_CSR, ep_sel_r)) begin
         rd_byte = csr_val;
      end else if (f_ep0_hit(rd_idx_r, IDX_E0_CNT, ep_sel_r)) begin
         rd_byte[6:0] = cnt_r;
      end else if (f_ep0_hit(rd_idx_r, IDX_E0_FIFO, ep_sel_r)) begin
         rd_byte = mem_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         rd_go_r <= 1'b0;
         rd_idx_r <= '0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_OKAY;
      end else begin
         rd_go_r <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            rd_idx_r <= s_axi_araddr[ADDR_W-1:2];
            rd_go_r <= 1'b1;
         end
         if (rd_go_r) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= f_mapped(rd_idx_r) ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   assign sw_csr_wr = wr_ok && f_ep0_hit(aw_idx_r, IDX_E0_CSR, ep_sel_r);
   assign sw_fifo_wr = wr_ok && f_ep0_hit(aw_idx_r, IDX_E0_FIFO, ep_sel_r) && !in_rdy_r && tx_len_r < MAX7;
   assign sw_fifo_rd = rd_go_r && f_ep0_hit(rd_idx_r, IDX_E0_FIFO, ep_sel_r);
   assign ep0_tok = tok_valid && tok_ep == EP0_SEL && tok_pid != PID_SOF;

   // control FIFO: receiver and software writes share one port
   assign mem_we = (tr_r == TR_RX && rx_valid && rx_take_r && rx_len_r < MAX7) || sw_fifo_wr;
   assign mem_wa = tr_r == TR_RX ? rx_len_r[AW-1:0] : tx_len_r[AW-1:0];
   assign mem_wd = tr_r == TR_RX ? rx_data : w_dat_r;
   assign mem_ra = tr_r == TR_TX ? tx_ptr_r[AW-1:0] : sw_rd_ptr_r[AW-1:0];

   ueci_fifo_mem #(.DEPTH(EP0_MAX), .AW(AW)) u_mem (
      .aclk(aclk),
      .wr_en(mem_we),
      .wr_addr(mem_wa),
      .wr_data(mem_wd),
      .rd_addr(mem_ra),
      .rd_data_r(mem_q)
   );

   // control endpoint engine
   always_ff @(posedge aclk) begin
      if (!aresetn || ln_rise[LN_RST]) begin
         phase_r <= PH_IDLE;
         tr_r <= TR_NONE;
         {out_rdy_r, in_rdy_r, sent_stl_r, dend_r, setup_end_r, send_stl_r} <= 6'h00;
         {ep0_evt_r, rx_setup_r, rx_take_r, rx_ovf_r, status_r, fetch_r} <= 6'h00;
         {rx_len_r, cnt_r, tx_len_r, tx_ptr_r, sw_rd_ptr_r} <= 35'h0_0000_0000;
         resp_valid <= 1'b0;
         resp_kind <= HS_ACK;
         resp_len <= 7'h00;
         {tx_valid, tx_data, tx_last} <= 10'h000;
      end else begin
         resp_valid <= 1'b0;
         ep0_evt_r <= 1'b0;
         if (sw_csr_wr) begin
            if (w_dat_r[CS_SRV_SU]) setup_end_r <= 1'b0;
            if (w_dat_r[CS_SRV_OUT]) out_rdy_r <= 1'b0;
            send_stl_r <= w_dat_r[CS_SEND_STL];
            if (w_dat_r[CS_DEND]) dend_r <= 1'b1;
            if (!w_dat_r[CS_SENT_STL]) sent_stl_r <= 1'b0;
            if (w_dat_r[CS_IN_RDY]) in_rdy_r <= 1'b1;
         end
         if (sw_fifo_wr) tx_len_r <= tx_len_r + 7'h01;
         if (sw_fifo_rd) sw_rd_ptr_r <= sw_rd_ptr_r + 7'h01;
         if (ep0_tok) begin
            tr_r <= TR_NONE;
            tx_valid <= 1'b0;
            fetch_r <= 1'b0;
            resp_len <= 7'h00;
            if (tok_pid == PID_IN) begin
               resp_valid <= 1'b1;
               if (send_stl_r || (phase_r == PH_TX_DONE && dend_r)) begin
                  resp_kind <= HS_STALL;
                  sent_stl_r <= 1'b1;
                  send_stl_r <= 1'b0;
                  ep0_evt_r <= 1'b1;
                  phase_r <= PH_IDLE;
               end else if ((phase_r == PH_RX_MODE || phase_r == PH_RX_DONE) && dend_r) begin
                  resp_kind <= HS_DATA;
                  tr_r <= TR_ACK;
                  status_r <= 1'b1;
               end else if (phase_r == PH_RX_MODE) begin
                  resp_kind <= HS_NAK;
                  setup_end_r <= 1'b1;
                  ep0_evt_r <= 1'b1;
                  phase_r <= PH_IDLE;
               end else if (!in_rdy_r) begin
                  resp_kind <= HS_NAK;
               end else begin
                  resp_kind <= HS_DATA;
                  resp_len <= tx_len_r;
                  tx_ptr_r <= 7'h00;
                  status_r <= 1'b0;
                  tr_r <= tx_len_r == 7'h00 ? TR_ACK : TR_TX;
                  phase_r <= PH_TX_MODE;
               end
            end else begin
               if (phase_r == PH_TX_MODE || (tok_pid == PID_SETUP && phase_r == PH_RX_MODE)) begin
                  setup_end_r <= 1'b1;
                  ep0_evt_r <= 1'b1;
                  phase_r <= PH_IDLE;
               end
               tr_r <= TR_RX;
               rx_setup_r <= tok_pid == PID_SETUP;
               rx_take_r <= tok_pid == PID_SETUP || !out_rdy_r;
               rx_len_r <= 7'h00;
               rx_ovf_r <= 1'b0;
            end
         end else if (tr_r == TR_RX && rx_err) begin
            tr_r <= TR_NONE;
         end else if (tr_r == TR_RX && rx_end) begin
            tr_r <= TR_NONE;
            if (rx_setup_r) begin
               if (rx_len_r == SETUP_LEN && !rx_ovf_r) begin
                  out_rdy_r <= 1'b1;
                  cnt_r <= rx_len_r;
                  sw_rd_ptr_r <= 7'h00;
                  in_rdy_r <= 1'b0;
                  tx_len_r <= 7'h00;
                  dend_r <= 1'b0;
                  phase_r <= PH_IDLE;
                  resp_valid <= 1'b1;
                  resp_kind <= HS_ACK;
                  ep0_evt_r <= 1'b1;
               end
            end else if (send_stl_r || rx_ovf_r || ((phase_r == PH_RX_MODE || phase_r == PH_RX_DONE) && dend_r) ||
                         (phase_r == PH_TX_DONE && rx_data1 && rx_len_r != 7'h00)) begin
               resp_valid <= 1'b1;
               resp_kind <= HS_STALL;
               sent_stl_r <= 1'b1;
               send_stl_r <= 1'b0;
               ep0_evt_r <= 1'b1;
               phase_r <= PH_IDLE;
            end else if (phase_r == PH_TX_DONE) begin
               resp_valid <= 1'b1;
               resp_kind <= HS_ACK;
               dend_r <= 1'b0;
               ep0_evt_r <= 1'b1;
               phase_r <= PH_IDLE;
            end else if (!rx_take_r) begin
               resp_valid <= 1'b1;
               resp_kind <= HS_NAK;
            end else begin
               out_rdy_r <= 1'b1;
               cnt_r <= rx_len_r;
               sw_rd_ptr_r <= 7'h00;
               in_rdy_r <= 1'b0;
               tx_len_r <= 7'h00;
               resp_valid <= 1'b1;
               resp_kind <= HS_ACK;
               ep0_evt_r <= 1'b1;
               phase_r <= rx_len_r < MAX7 ? PH_RX_DONE : PH_RX_MODE;
            end
         end else if (tr_r == TR_RX && rx_valid) begin
            if (rx_len_r == MAX7) begin
               rx_ovf_r <= 1'b1;
            end else begin
               rx_len_r <= rx_len_r + 7'h01;
            end
         end else if (tr_r == TR_ACK && host_ack) begin
            tr_r <= TR_NONE;
            ep0_evt_r <= 1'b1;
            if (status_r) begin
               dend_r <= 1'b0;
               phase_r <= PH_IDLE;
            end else begin
               in_rdy_r <= 1'b0;
               tx_len_r <= 7'h00;
               phase_r <= (tx_len_r < MAX7 || dend_r) ? PH_TX_DONE : PH_TX_MODE;
            end
         end else if (tr_r == TR_TX) begin
            if (tx_valid) begin
               if (tx_ready) begin
                  tx_valid <= 1'b0;
                  if (tx_last) tr_r <= TR_ACK;
               end
            end else if (fetch_r) begin
               tx_valid <= 1'b1;
               tx_data <= mem_q;
               tx_last <= tx_ptr_r == tx_len_r - 7'h01;
               tx_ptr_r <= tx_ptr_r + 7'h01;
               fetch_r <= 1'b0;
            end else begin
               fetch_r <= 1'b1;
            end
         end
      end
   end
endmodule // ueci_top
`default_nettype wire

/* File: verilog/ueci_tb_placeholder_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verif/ueci_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ueci_assertions import ueci_pkg::*; (
   input wire logic aclk, aresetn, s_axi_rvalid, tok_valid, rx_valid, rx_end, rx_err,
   input wire logic resp_valid, tx_valid, tx_ready, usb_irq,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] tok_pid, resp_kind,
   input wire logic [3:0] tok_ep,
   input wire logic [7:0] tx_data);
   logic su_r;
   logic [7:0] n_r;
   wire logic tin = tok_valid && tok_pid == PID_IN && tok_ep == EP0_SEL;
   // bytes since the last token
   always_ff @(posedge aclk) n_r <= (!aresetn || tok_valid) ? 8'h00 : n_r + {7'h00, rx_valid};
   always_ff @(posedge aclk) su_r <= aresetn && (tok_valid ? tok_pid == PID_SETUP && tok_ep == EP0_SEL : su_r);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   a_hi: assert property (p_hi) else $error("rdata high bits");
   property p_in; tin |=> resp_valid; endproperty
   a_in: assert property (p_in) else $error("IN unanswered");
   property p_ink; tin |=> resp_kind != HS_ACK; endproperty
   a_ink: assert property (p_ink) else $error("IN got ACK");
   property p_err; rx_err |=> !resp_valid; endproperty
   a_err: assert property (p_err) else $error("bad packet answered");
   property p_bsu; rx_end && su_r && n_r != 8'h08 |=> !resp_valid; endproperty
   a_bsu: assert property (p_bsu) else $error("short setup answered");
   property p_gsu; rx_end && su_r && n_r == 8'h08 |=> resp_valid && resp_kind == HS_ACK; endproperty
   a_gsu: assert property (p_gsu) else $error("setup not acked");
   property p_tx; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   a_tx: assert property (p_tx) else $error("tx byte dropped");
   property p_irq; $rose(aresetn) |-> !usb_irq; endproperty
   a_irq: assert property (p_irq) else $error("irq after reset");
   c_in: cover property (tin);
   c_su: cover property (rx_end && su_r);
   c_stl: cover property (resp_valid && resp_kind == HS_STALL);
endmodule // ueci_assertions
bind ueci_top ueci_assertions i_chk (.*);
`default_nettype wire

/* File: verif/ueci_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ueci_host import ueci_pkg::*; (
   input wire logic aclk, tx_valid, tx_last,
   output var logic tok_valid, rx_valid, rx_end, rx_err, rx_data1, host_ack, tx_ready,
   output var logic [1:0] tok_pid,
   output var logic [3:0] tok_ep,
   output var logic [7:0] rx_data);
   initial {tok_valid, rx_valid, rx_end, rx_err, rx_data1, host_ack, tx_ready, tok_pid, tok_ep, rx_data} = '0;
   // slow sink, ready on every other cycle
   always @(posedge aclk) tx_ready <= ~tx_ready;
   always @(posedge aclk) host_ack <= tx_valid && tx_ready && tx_last;
   task automatic send(input logic [1:0] pid, input int n, input logic bad);
      @(posedge aclk);
      {tok_valid, tok_pid, tok_ep} <= {1'b1, pid, 4'h0};
      @(posedge aclk);
      tok_valid <= 1'b0;
      if (pid == PID_IN) return;
      repeat (n) begin
         {rx_valid, rx_data} <= {1'b1, rx_data + 8'h11};
         @(posedge aclk);
      end
      {rx_valid, rx_data, rx_end, rx_err} <= {1'b0, ~rx_data, !bad, bad};
      @(posedge aclk);
      {rx_end, rx_err} <= 2'h0;
   endtask
endmodule // ueci_host
`default_nettype wire

/* File: verif/ueci_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define C(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module ueci_top_tb_top import ueci_pkg::*;;
   int n_errors = 0, n_checks = 0;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, line_reset = 0, line_resume = 0, line_suspend = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, tok_valid, rx_valid, rx_end, rx_err, rx_data1, host_ack;
   logic resp_valid, tx_valid, tx_last, tx_ready, usb_irq;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rx_data, tx_data, d;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, tok_ep;
   logic [2:0] in_ep_event = 0, out_ep_event = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, tok_pid, resp_kind, k_r;
   logic [6:0] resp_len, l_r;
   logic [23:0] t_r;
   ueci_top #(.FRAME_CYCLES(50), .EP0_MAX(EP0_MAX_DEF)) i_dut (.*);
   ueci_host i_host (.*);
   initial forever #2.5 aclk = ~aclk;
   always @(posedge aclk) if (resp_valid) {k_r, l_r} <= {resp_kind, resp_len};
   // bytes the host takes off the data stream
   always @(posedge aclk) if (tx_valid && tx_ready) t_r <= {t_r[15:0], tx_data};
   task automatic wr(input logic [5:0] i, input logic [7:0] v);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {i, 26'h0, v, 3'h7};
      fork
         begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
         begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] i);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {i, 4'h3};
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata[7:0];
   endtask
   task automatic t_regs;
      rd(IDX_IN_IE); `C("in_ie", 8'h0F, d)
      rd(IDX_OUT_IE); `C("out_ie", 8'h0E, d)
      rd(IDX_CM_IE); `C("cm_ie", 8'h06, d)
      wr(IDX_OUT_IE, 8'hFF); rd(IDX_OUT_IE); `C("out_ie rw", 8'h0E, d)
      wr(IDX_IN_IE, 8'hF5); rd(IDX_IN_IE); `C("in_ie rw", 8'h05, d)
      rd(6'h3F); `C("unmapped", AXI_SLVERR, s_axi_rresp)
   endtask
   task automatic t_flags;
      wr(IDX_CM_IE, 8'h00);
      line_reset <= 1'b1;
      repeat (6) @(posedge aclk);
      line_reset <= 1'b0;
      repeat (6) @(posedge aclk);
      `C("irq masked", 1'b0, usb_irq)
      wr(IDX_CM_IE, 8'h04); repeat (2) @(posedge aclk); `C("irq", 1'b1, usb_irq)
      rd(IDX_CM_FLG); `C("cm_flg", 8'h04, d)
      rd(IDX_CM_FLG); `C("cm_flg clr", 8'h00, d)
      `C("irq clr", 1'b0, usb_irq)
   endtask
   task automatic t_ep0;
      wr(IDX_EP_SEL, 8'h00);
      i_host.send(PID_SETUP, 7, 1'b0);
      i_host.send(PID_SETUP, 8, 1'b1);
      rd(IDX_E0_CSR); `C("bad setup", 1'b0, d[CS_OUT_RDY])
      i_host.send(PID_SETUP, 8, 1'b0);
      rd(IDX_E0_CSR); `C("out_ready", 1'b1, d[CS_OUT_RDY])
      `C("setup ack", HS_ACK, k_r)
      rd(IDX_E0_CNT); `C("count", 7'h08, d[6:0])
      rd(IDX_IN_FLG); `C("ep0 flag", 1'b1, d[0])
      i_host.send(PID_IN, 0, 1'b0); repeat (3) @(posedge aclk); `C("nak", HS_NAK, k_r)
      wr(IDX_E0_CSR, 8'h60); i_host.send(PID_IN, 0, 1'b0); rd(IDX_E0_CSR);
      `C("stall", HS_STALL, k_r)
      `C("csr", 2'h2, {d[CS_SENT_STL], d[CS_SRV_SU]})
   endtask
   task automatic t_in;
      i_host.send(PID_SOF, 0, 1'b0); rd(IDX_CM_FLG); `C("sof", 1'b1, d[CM_SOF])
      repeat (60) @(posedge aclk); rd(IDX_CM_FLG); `C("sof synth", 1'b1, d[CM_SOF])
      i_host.send(PID_SETUP, 8, 1'b0);
      rd(IDX_E0_FIFO); wr(IDX_E0_CSR, 8'h40);
      rd(IDX_E0_CSR); `C("serviced", 1'b0, d[CS_OUT_RDY])
      wr(IDX_E0_FIFO, 8'hAA); wr(IDX_E0_FIFO, 8'hBB); wr(IDX_E0_FIFO, 8'hCC);
      wr(IDX_E0_CSR, 8'h0A); rd(IDX_IN_FLG);
      i_host.send(PID_IN, 0, 1'b0); repeat (40) @(posedge aclk);
      `C("in kind", HS_DATA, k_r)
      `C("in len", 7'h03, l_r)
      `C("in bytes", 24'hAABBCC, t_r)
      rd(IDX_IN_FLG); `C("in done", 1'b1, d[0])
      rd(IDX_E0_CSR); `C("in_ready clr", 1'b0, d[CS_IN_RDY])
      i_host.send(PID_IN, 0, 1'b0); repeat (3) @(posedge aclk); `C("in stall", HS_STALL, k_r)
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_flags;
      t_ep0;
      t_in;
      end_sim;
   end
   initial begin
      #50000;
      n_errors++;
      end_sim;
   end
endmodule // ueci_top_tb_top
`default_nettype wire
